// [bench/fsps_core_model.sv]
`timescale 1ns/1ps
`default_nettype none

module fsps_core_model (
    // Clock.
    input  wire logic                    clk_in,
    // Instruction requests and program memory contents.
    output var fsps_pkg::fsps_core_req_s core_req_out,
    output logic [15:0]                  pmem_word_out
);
    // Program memory holds a pattern derived from the word address.
    assign pmem_word_out = {core_req_out.ptr[15:1], 1'b0} ^ 16'h3c5a;

    // Start idle with a data pair that matches nothing in use.
    initial core_req_out = '{store: 1'b0, load: 1'b0, ptr: 16'h0000, data_word_pair: 16'h5aa5};

    // store timing
    // The store issues gap cycles after the control write edge.
    task automatic store(input logic [15:0] p, input logic [15:0] d, input int gap);
        repeat (gap - 1) @(posedge clk_in);
        core_req_out <= '{store: 1'b1, load: 1'b0, ptr: p, data_word_pair: d};
        @(posedge clk_in);
        core_req_out.store          <= 1'b0;
        core_req_out.data_word_pair <= ~d;  // Released data must not look valid.
    endtask

    task automatic load(input logic [15:0] p, input int gap);
        repeat (gap - 1) @(posedge clk_in);
        core_req_out.load <= 1'b1;
        core_req_out.ptr  <= p;
        @(posedge clk_in);
        core_req_out.load <= 1'b0;
    endtask

    // Moves the pointer without any instruction.
    task automatic point(input logic [15:0] p);
        core_req_out.ptr <= p;
    endtask
endmodule

`default_nettype wire

// [bench/tb_flash_self_programming_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fsps_map.svh"

module tb_flash_self_programming_sequencer;
    logic                      clk_in   = 1'b0;
    logic                      reset_in = 1'b1;
    fsps_pkg::fsps_reg_req_s   req      = '0;
    fsps_pkg::fsps_core_req_s  creq;
    fsps_pkg::fsps_flash_cmd_s cmd;
    logic [15:0]               pmem;
    logic [15:0]               buf_word;
    logic [7:0]                rdata;
    logic [7:0]                lpm_data;
    logic                      lpm_valid;
    logic                      halt;
    logic                      start;
    logic                      ee_busy  = 1'b0;
    logic [7:0]                nv [4]   = '{8'h5e, 8'hc2, 8'hf9, 8'hd7};
    int                        failures = 0;
    int                        n_tests  = 0;
    int                        n;

    always #4 clk_in = ~clk_in;

    fsps_core_model core (.clk_in(clk_in), .core_req_out(creq), .pmem_word_out(pmem));

    // Short programming time keeps the run brief.
    fsps_sequencer #(.PROG_CYCLES(20)) DUT (
        .clk_in(clk_in), .reset_in(reset_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .core_req_in(creq), .pmem_word_in(pmem), .lpm_data_out(lpm_data),
        .lpm_valid_out(lpm_valid), .halt_out(halt), .eeprom_write_busy_flag_in(ee_busy),
        .lock_bits_in(nv[1]), .fuse_low_byte_in(nv[0]), .fuse_high_byte_in(nv[3]),
        .fuse_extended_byte_in(nv[2]), .flash_cmd_out(cmd), .buf_word_out(buf_word),
        .flash_start_out(start));

    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] pm_byte(input logic [15:0] p);
        logic [15:0] w;
        w = {p[15:1], 1'b0} ^ 16'h3c5a;
        return p[0] ? w[15:8] : w[7:0];
    endfunction

    task automatic reg_wr(input logic [7:0] d);
        req <= '{addr: `FSPS_ADDR_CTRL, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        req.wr <= 1'b0;
    endtask

    // Read data is looked at only in the cycle after the strobe.
    task automatic reg_rd_at(input logic [7:0] a, input logic [7:0] exp);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        req.rd <= 1'b0;
        #1;
        check(16'(rdata), 16'(exp));
    endtask

    task automatic reg_rd(input logic [7:0] exp);
        reg_rd_at(`FSPS_ADDR_CTRL, exp);
    endtask

    task automatic buf_chk(input logic [4:0] slot, input logic [15:0] exp);
        core.point({10'h000, slot, 1'b0});
        repeat (2) @(posedge clk_in);
        #1;
        check(buf_word, exp);
    endtask

    // Counts halt cycles under a bound so a stuck halt cannot hang the run.
    task automatic wait_halt(input int first);
        n = first;
        while (halt === 1'b1 && n < 200) begin
            @(posedge clk_in);
            #1;
            n++;
        end
    endtask

    // Control write then store after gap cycles; go says whether it must start.
    task automatic op(input logic [7:0] pat, input logic [15:0] p, input int gap,
                      input logic go);
        reg_wr(pat);
        core.store(p, 16'hbeef, gap);
        #1;
        check(16'(halt), 16'(go));
        if (go) begin
            check(16'(start), 16'h0001);
            check({14'h0, cmd.erase, cmd.write}, {14'h0, pat[1], pat[2]});
            check(16'(cmd.page), 16'(p[15:6]));
            reg_rd(pat);
            wait_halt(1);
            check(16'(n), 16'd20);
        end
        reg_rd(8'h00);
    endtask

    task automatic test_done;
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Whole sequence needs under 2000 cycles.
    initial begin
        #100000;
        failures++;
        test_done();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        reg_rd(8'h00);
        for (int i = 0; i < 4; i++) begin
            reg_wr(8'(`FSPS_CMD_LFR));
            core.load(16'(i), (i == 0) ? 3 : 1);
            #1;
            check(16'(lpm_valid), 16'h0001);
            check(16'(lpm_data), 16'(nv[i]));
        end
        reg_wr(8'(`FSPS_CMD_LFR));
        core.load(16'h0001, 4);
        #1;
        check(16'(lpm_data), 16'(pm_byte(16'h0001)));
        reg_rd(8'h00);
        for (int i = 0; i < 2; i++) begin
            core.load(16'h1234 + 16'(i), 1);
            #1;
            check(16'(lpm_data), 16'(pm_byte(16'h1234 + 16'(i))));
        end
        // Erase first with junk low pointer bits, then fill out of order.
        op(8'(`FSPS_CMD_ERASE), {10'h2a5, 6'h3f}, 4, 1'b1);
        reg_wr(8'(`FSPS_CMD_LOAD));
        core.store(16'h0014, 16'h1111, 1);
        reg_wr(8'(`FSPS_CMD_LOAD));
        core.store(16'h0006, 16'h2222, 4);
        buf_chk(5'd10, 16'h1111);
        buf_chk(5'd3, 16'h2222);
        buf_chk(5'd4, 16'hffff);
        op(8'(`FSPS_CMD_WRITE), {10'h2a5, 6'h00}, 2, 1'b1);
        buf_chk(5'd10, 16'hffff);
        op(8'(`FSPS_CMD_ERASE), 16'h0400, 5, 1'b0);
        op(8'h07, 16'h0400, 1, 1'b0);
        op(8'h0b, 16'h0400, 1, 1'b0);
        op(8'h13, 16'h0400, 1, 1'b0);
        reg_wr(8'(`FSPS_CMD_LOAD));
        core.store(16'h0002, 16'h3333, 1);
        reg_wr(8'(`FSPS_CMD_RWW));
        buf_chk(5'd1, 16'hffff);
        // Let the rww arming run out before the control register is read.
        repeat (2) @(posedge clk_in);
        // EEPROM write in mid-load, then attempts while it is busy.
        reg_rd(8'h00);
        reg_wr(8'(`FSPS_CMD_LOAD));
        core.store(16'h0004, 16'h4444, 1);
        // Busy rises inside an erase window, so the late store must be refused.
        reg_wr(8'(`FSPS_CMD_ERASE));
        ee_busy <= 1'b1;
        core.store(16'h0400, 16'h0000, 4);
        #1;
        check(16'(halt), 16'h0000);
        repeat (4) @(posedge clk_in);
        buf_chk(5'd2, 16'hffff);
        reg_rd_at(`FSPS_ADDR_EE_BUSY, 8'h01);
        op(8'(`FSPS_CMD_ERASE), 16'h0400, 1, 1'b0);
        reg_wr(8'(`FSPS_CMD_LFR));
        core.load(16'h0001, 1);
        #1;
        check(16'(lpm_data), 16'(pm_byte(16'h0001)));
        ee_busy <= 1'b0;
        repeat (4) @(posedge clk_in);
        reg_rd_at(`FSPS_ADDR_EE_BUSY, 8'h00);
        // Reset in mid-erase must not abort the erase.
        reg_wr(8'(`FSPS_CMD_LOAD));
        core.store(16'h000e, 16'h7777, 1);
        reg_wr(8'(`FSPS_CMD_ERASE));
        core.store(16'h0800, 16'h0000, 1);
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b1;
        @(posedge clk_in);
        reset_in <= 1'b0;
        #1;
        check(16'(halt), 16'h0001);
        wait_halt(0);
        check(16'(halt), 16'h0000);
        buf_chk(5'd7, 16'hffff);
        test_done();
    end
endmodule

`default_nettype wire

// [verilog/fsps_map.svh]
`ifndef FSPS_MAP_SVH
`define FSPS_MAP_SVH

// Port address of the control/status register on the plain register port.
`define FSPS_ADDR_CTRL        8'h37
`define FSPS_ADDR_EE_BUSY     8'h38

// Control register bit positions.
`define FSPS_BIT_IE           7
`define FSPS_BIT_RWW_BUSY     6
`define FSPS_BIT_RSVD         5
`define FSPS_BIT_RWW_EN       4
`define FSPS_BIT_LFR          3
`define FSPS_BIT_PGWR         2
`define FSPS_BIT_PGER         1
`define FSPS_BIT_SPEN         0

// Lower five bit command patterns.
`define FSPS_CMD_RWW          5'h11
`define FSPS_CMD_LFR          5'h09
`define FSPS_CMD_WRITE        5'h05
`define FSPS_CMD_ERASE        5'h03
`define FSPS_CMD_LOAD         5'h01

// Pointer values that select lock and fuse bytes.
`define FSPS_Z_FUSE_LOW       16'h0000
`define FSPS_Z_LOCK           16'h0001
`define FSPS_Z_FUSE_EXT       16'h0002
`define FSPS_Z_FUSE_HIGH      16'h0003

// Arming windows in cycles.
`define FSPS_STORE_WIN        3'h4
`define FSPS_LOAD_WIN         3'h3

// Page geometry: 32 words per page, word field is pointer bits 5:1.
`define FSPS_WORD_LSB         1
`define FSPS_WORD_W           5
`define FSPS_PAGE_LSB         6
`define FSPS_PAGE_W           10
`define FSPS_PAGE_WORDS       32

// Programming time, 4.5 ms at 8 ns per cycle.
`define FSPS_PROG_NS          4500000
`define FSPS_CLK_NS           8
`define FSPS_PROG_CYC         (`FSPS_PROG_NS / `FSPS_CLK_NS)

`endif

// [verilog/fsps_pkg.sv]
`default_nettype none
package fsps_pkg;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ARMED = 4'b0010,
        ST_ERASE = 4'b0100,
        ST_WRITE = 4'b1000
    } fsps_state_e;

    // Register port request.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } fsps_reg_req_s;

    // Core store/load instruction request.
    typedef struct packed {
        logic        store;
        logic        load;
        logic [15:0] ptr;
        logic [15:0] data_word_pair;
    } fsps_core_req_s;

    // Flash array command.
    typedef struct packed {
        logic        erase;
        logic        write;
        logic [9:0]  page;
    } fsps_flash_cmd_s;

    typedef struct packed {
        fsps_state_e  state;
        logic [7:0]   ctrl;
        logic [2:0]   win;
        logic [31:0]  timer;
        logic         halt;
        logic [7:0]   rdata;
        logic [7:0]   lpm_data;
        logic         lpm_valid;
        logic [9:0]   op_page;
        logic         flash_start;
        logic [31:0]  loaded;
        logic         ee_q1;
        logic         ee_q2;
        logic         ee_prev;
    } fsps_state_s;

endpackage
`default_nettype wire

// [verilog/fsps_sequencer.sv]
// How it works
// - Erase pattern then store within four cycles erases
// - Erase uses only page field of pointer
// - Core halted for whole erase
// - Load pattern plus store fills buffer slot
// - Buffer clears after write, rww enable, reset
// - EEPROM write during loading discards buffer
// - Write pattern plus store programs page
// - Core halted while page programmed from buffer
// - Buffer slots load in any order
// - Store accepted from any code address
// - Loads use byte addressing, bit zero selects
// - EEPROM busy blocks programming and fuse reads
// - Pointer one returns lock bits within three
// - Read arming self clears on completion, timeout
// - Pointers zero, three, two return fuse bytes
// - Programmed bits read zero, unprogrammed one
// - Disarmed loads are ordinary program reads
// - Reset does not abort erase or write
// - Control register bit layout as defined
// - Enable bit clears after store or timeout
// - Undefined command patterns have no effect
`timescale 1ns/1ps
`default_nettype none
`include "fsps_map.svh"

module fsps_sequencer #(
    parameter int unsigned PROG_CYCLES = `FSPS_PROG_CYC
) (
    // Clock and reset.
    input  wire logic                   clk_in,
    input  wire logic                   reset_in,
    // Register port.
    input  wire fsps_pkg::fsps_reg_req_s reg_req_in,
    output logic [7:0]                  reg_rdata_out,
    // Core store/load requests and program memory read data.
    input  wire fsps_pkg::fsps_core_req_s core_req_in,
    input  wire logic [15:0]            pmem_word_in,
    output logic [7:0]                  lpm_data_out,
    output logic                        lpm_valid_out,
    output logic                        halt_out,
    // EEPROM write busy flag from the EEPROM block, another domain.
    input  wire logic                   eeprom_write_busy_flag_in,
    // Non-volatile lock and fuse bytes, as stored.
    input  wire logic [7:0]             lock_bits_in,
    input  wire logic [7:0]             fuse_low_byte_in,
    input  wire logic [7:0]             fuse_high_byte_in,
    input  wire logic [7:0]             fuse_extended_byte_in,
    // Flash array side.
    output fsps_pkg::fsps_flash_cmd_s   flash_cmd_out,
    output logic [15:0]                 buf_word_out,
    output logic                        flash_start_out
);

    // ----------------------------------------------------------------
    // Page buffer
    // ----------------------------------------------------------------

    // The buffer array sits outside the state struct so reset only needs the
    // valid mask; stale words are never read while their valid bit is clear.
    logic [15:0] page_buf [`FSPS_PAGE_WORDS];
    logic [15:0]             buf_word_q;

    fsps_pkg::fsps_state_s s_q;
    fsps_pkg::fsps_state_s s_d;

    logic [4:0]              cmd5;
    logic                    ctrl_wr;
    logic                    ee_busy;
    logic                    ee_start;
    logic                    armed_lfr;
    logic                    lfr_take;
    logic                    store_ok;
    logic [`FSPS_WORD_W-1:0] word_idx;
    logic [9:0]              page_idx;
    logic [7:0]              fuse_sel;
    logic [7:0]              pmem_byte;
    logic [7:0]              rd_val;

    assign cmd5     = reg_req_in.wdata[4:0];
    assign ctrl_wr  = reg_req_in.wr && (reg_req_in.addr == `FSPS_ADDR_CTRL);
    assign ee_busy  = s_q.ee_q2;
    assign ee_start = s_q.ee_q2 && !s_q.ee_prev;
    assign armed_lfr = s_q.state == fsps_pkg::ST_ARMED && s_q.ctrl[`FSPS_BIT_LFR];
    assign lfr_take = armed_lfr && core_req_in.load && s_q.win < `FSPS_LOAD_WIN && !ee_busy;
    // any address: no code address qualifies the store.
    assign store_ok = core_req_in.store && s_q.state == fsps_pkg::ST_ARMED && !ee_busy;
    assign page_idx = core_req_in.ptr[`FSPS_PAGE_LSB +: `FSPS_PAGE_W];
    assign word_idx = core_req_in.ptr[`FSPS_WORD_LSB +: `FSPS_WORD_W];
    assign pmem_byte = core_req_in.ptr[0] ? pmem_word_in[15:8] : pmem_word_in[7:0];

    // Lock and fuse byte select; stored values are passed as is.
    // fuse select
    always_comb begin
        case (core_req_in.ptr)
            `FSPS_Z_FUSE_LOW:  fuse_sel = fuse_low_byte_in;
            `FSPS_Z_LOCK:      fuse_sel = lock_bits_in;
            `FSPS_Z_FUSE_EXT:  fuse_sel = fuse_extended_byte_in;
            `FSPS_Z_FUSE_HIGH: fuse_sel = fuse_high_byte_in;
            default:           fuse_sel = 8'hff;
        endcase
    end

    // Register read mux; busy bit and reserved bit read zero.
    // register layout
    always_comb begin
        rd_val = 8'h00;
        if (reg_req_in.addr == `FSPS_ADDR_CTRL) begin
            rd_val = s_q.ctrl;
            rd_val[`FSPS_BIT_RWW_BUSY] = 1'b0;
            rd_val[`FSPS_BIT_RSVD] = 1'b0;
        end else if (reg_req_in.addr == `FSPS_ADDR_EE_BUSY) begin
            rd_val = {7'h00, ee_busy};
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------

    always_comb begin
        s_d = s_q;
        s_d.flash_start = 1'b0;
        s_d.lpm_valid   = 1'b0;
        s_d.ee_q1       = eeprom_write_busy_flag_in;
        s_d.ee_q2       = s_q.ee_q1;
        s_d.ee_prev     = s_q.ee_q2;
        if (reg_req_in.rd) begin
            s_d.rdata = rd_val;
        end

        if (ee_start) begin
            s_d.loaded = 32'h0;
        end

        case (s_q.state)
            fsps_pkg::ST_IDLE: begin
                if (ctrl_wr) begin
                    s_d.ctrl[`FSPS_BIT_IE] = reg_req_in.wdata[`FSPS_BIT_IE];
                end
                // eeprom block and only defined patterns arm.
                if (ctrl_wr && !ee_busy && (cmd5 == `FSPS_CMD_ERASE ||
                        cmd5 == `FSPS_CMD_WRITE || cmd5 == `FSPS_CMD_LOAD ||
                        cmd5 == `FSPS_CMD_LFR || cmd5 == `FSPS_CMD_RWW)) begin
                    s_d.ctrl[4:0] = cmd5;
                    s_d.state     = fsps_pkg::ST_ARMED;
                    s_d.win       = 3'h0;
                    if (cmd5 == `FSPS_CMD_RWW) begin
                        s_d.loaded = 32'h0;
                    end
                end
            end
            fsps_pkg::ST_ARMED: begin
                s_d.win = s_q.win + 3'h1;
                if (ctrl_wr) begin
                    s_d.ctrl[`FSPS_BIT_IE] = reg_req_in.wdata[`FSPS_BIT_IE];
                end
                if (lfr_take) begin
                    // lock read and stored polarity returned unchanged.
                    s_d.lpm_data  = fuse_sel;
                    s_d.lpm_valid = 1'b1;
                    s_d.ctrl[4:0] = 5'h00;
                    s_d.state     = fsps_pkg::ST_IDLE;
                end else if (store_ok && s_q.ctrl[`FSPS_BIT_PGER]) begin
                    s_d.op_page     = page_idx;
                    s_d.timer       = 32'(PROG_CYCLES);
                    s_d.halt        = 1'b1;
                    s_d.flash_start = 1'b1;
                    s_d.state       = fsps_pkg::ST_ERASE;
                end else if (store_ok && s_q.ctrl[`FSPS_BIT_PGWR]) begin
                    s_d.op_page     = page_idx;
                    s_d.timer       = 32'(PROG_CYCLES);
                    s_d.halt        = 1'b1;
                    s_d.flash_start = 1'b1;
                    s_d.state       = fsps_pkg::ST_WRITE;
                end else if (store_ok && s_q.ctrl[4:0] == `FSPS_CMD_LOAD) begin
                    s_d.loaded[word_idx] = 1'b1;
                    s_d.ctrl[4:0] = 5'h00;
                    s_d.state     = fsps_pkg::ST_IDLE;
                end else if (store_ok) begin
                    // Store with rww or read arming just completes.
                    s_d.ctrl[4:0] = 5'h00;
                    s_d.state     = fsps_pkg::ST_IDLE;
                end else if ((armed_lfr && s_q.win == `FSPS_LOAD_WIN - 3'h1) ||
                        s_q.win == `FSPS_STORE_WIN - 3'h1) begin
                    // read timeout and store timeout disarm.
                    s_d.ctrl[4:0] = 5'h00;
                    s_d.state     = fsps_pkg::ST_IDLE;
                end
            end
            fsps_pkg::ST_ERASE, fsps_pkg::ST_WRITE: begin
                // erase halt and write halt hold until timer ends.
                s_d.timer = s_q.timer - 32'h1;
                if (s_q.timer == 32'h1) begin
                    s_d.halt      = 1'b0;
                    s_d.ctrl[4:0] = 5'h00;
                    s_d.state     = fsps_pkg::ST_IDLE;
                    if (s_q.state == fsps_pkg::ST_WRITE) begin
                        s_d.loaded = 32'h0;
                    end
                end
            end
            default: begin
                s_d.state = fsps_pkg::ST_IDLE;
            end
        endcase

        // plain load; a blocked fuse read still answers as a plain read.
        if (core_req_in.load && !lfr_take) begin
            s_d.lpm_data  = pmem_byte;
            s_d.lpm_valid = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------

    // reset completes: a running operation keeps its state and timer.
    always_ff @(posedge clk_in) begin
        if (reset_in && s_q.state != fsps_pkg::ST_ERASE
                && s_q.state != fsps_pkg::ST_WRITE) begin
            s_q       <= '0;
            s_q.state <= fsps_pkg::ST_IDLE;
        end else begin
            s_q <= s_d;
            if (reset_in) begin
                s_q.loaded <= 32'h0;
            end
        end
    end

    // Buffer data store; unloaded slots read as erased ones.
    always_ff @(posedge clk_in) begin
        if (store_ok && s_q.ctrl[4:0] == `FSPS_CMD_LOAD) begin
            page_buf[word_idx] <= core_req_in.data_word_pair;
        end
        buf_word_q <= s_q.loaded[word_idx] ? page_buf[word_idx] : 16'hffff;
    end

    assign reg_rdata_out          = s_q.rdata;
    assign lpm_data_out           = s_q.lpm_data;
    assign lpm_valid_out          = s_q.lpm_valid;
    assign halt_out               = s_q.halt;
    assign flash_cmd_out.erase    = s_q.state == fsps_pkg::ST_ERASE;
    assign flash_cmd_out.write    = s_q.state == fsps_pkg::ST_WRITE;
    assign flash_cmd_out.page     = s_q.op_page;
    assign flash_start_out        = s_q.flash_start;
    assign buf_word_out           = buf_word_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------

    sequence erase_go_s;
        s_q.state == fsps_pkg::ST_ARMED && s_q.ctrl[4:0] == `FSPS_CMD_ERASE && store_ok;
    endsequence

    sequence write_go_s;
        s_q.state == fsps_pkg::ST_ARMED && s_q.ctrl[4:0] == `FSPS_CMD_WRITE && store_ok;
    endsequence

    sequence fuse_read_go_s;
        lfr_take;
    endsequence

    erase_starts_a: assert property (@(posedge clk_in) disable iff (reset_in)
        erase_go_s |=> s_q.state == fsps_pkg::ST_ERASE && halt_out && flash_start_out)
        else $error("erase did not start");

    erase_page_a: assert property (@(posedge clk_in) disable iff (reset_in)
        erase_go_s |=> flash_cmd_out.page == $past(page_idx))
        else $error("erase page wrong");

    erase_halt_a: assert property (@(posedge clk_in) disable iff (reset_in)
        s_q.state == fsps_pkg::ST_ERASE |-> halt_out)
        else $error("core not halted in erase");

    load_marks_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (store_ok && s_q.ctrl[4:0] == `FSPS_CMD_LOAD && !ee_start)
        |=> s_q.loaded[$past(word_idx)])
        else $error("load slot not marked");

    write_clear_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (s_q.state == fsps_pkg::ST_WRITE && s_q.timer == 32'h1) |=> s_q.loaded == 32'h0)
        else $error("buffer not cleared after write");

    ee_discard_a: assert property (@(posedge clk_in) disable iff (reset_in)
        ee_start |=> s_q.loaded == 32'h0 || $past(store_ok))
        else $error("buffer kept over eeprom write");

    write_halt_a: assert property (@(posedge clk_in) disable iff (reset_in)
        write_go_s |=> halt_out [*8])
        else $error("core not halted in write");

    ee_block_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (ee_busy && s_q.state == fsps_pkg::ST_ARMED) |=> !flash_start_out)
        else $error("programming during eeprom write");

    arm_timeout_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (s_q.state == fsps_pkg::ST_IDLE ##1 s_q.state == fsps_pkg::ST_ARMED)
        |-> ##[0:4] s_q.state != fsps_pkg::ST_ARMED)
        else $error("arming did not time out");

    bad_cmd_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (ctrl_wr && s_q.state == fsps_pkg::ST_IDLE && cmd5 == 5'h07)
        |=> s_q.state == fsps_pkg::ST_IDLE)
        else $error("undefined pattern armed");

    lock_read_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (fuse_read_go_s ##0 core_req_in.ptr == `FSPS_Z_LOCK)
        |=> lpm_valid_out && lpm_data_out == $past(lock_bits_in))
        else $error("lock byte not returned");

    fuse_high_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (fuse_read_go_s ##0 core_req_in.ptr == `FSPS_Z_FUSE_HIGH)
        |=> lpm_data_out == $past(fuse_high_byte_in))
        else $error("fuse high byte not returned");

    fuse_polarity_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (fuse_read_go_s ##0 core_req_in.ptr == `FSPS_Z_FUSE_LOW)
        |=> lpm_data_out == $past(fuse_low_byte_in))
        else $error("fuse low byte altered");

    read_disarm_a: assert property (@(posedge clk_in) disable iff (reset_in)
        fuse_read_go_s |=> s_q.state == fsps_pkg::ST_IDLE && !s_q.ctrl[`FSPS_BIT_LFR]
            && !s_q.ctrl[`FSPS_BIT_SPEN])
        else $error("read arming not cleared");

    read_timeout_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (armed_lfr && !core_req_in.load && s_q.win == `FSPS_LOAD_WIN - 3'h1)
        |=> s_q.state == fsps_pkg::ST_IDLE)
        else $error("read arming did not time out");

    plain_load_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (core_req_in.load && s_q.state == fsps_pkg::ST_IDLE)
        |=> lpm_valid_out && lpm_data_out == $past(pmem_byte))
        else $error("plain load data wrong");

    byte_select_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (core_req_in.load && s_q.state == fsps_pkg::ST_IDLE && core_req_in.ptr[0])
        |=> lpm_data_out == $past(pmem_word_in[15:8]))
        else $error("high byte not selected");

    enable_held_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (s_q.state == fsps_pkg::ST_ERASE || s_q.state == fsps_pkg::ST_WRITE)
        |-> s_q.ctrl[`FSPS_BIT_SPEN])
        else $error("enable bit dropped during operation");

    reserved_zero_a: assert property (@(posedge clk_in) disable iff (reset_in)
        reg_req_in.rd
        |=> !reg_rdata_out[`FSPS_BIT_RWW_BUSY] && !reg_rdata_out[`FSPS_BIT_RSVD])
        else $error("busy or reserved bit read as one");

    // No disable here: this one must see the reset edge itself.
    reset_keeps_a: assert property (@(posedge clk_in)
        (reset_in && s_q.state == fsps_pkg::ST_ERASE && s_q.timer != 32'h1)
        |=> s_q.state == fsps_pkg::ST_ERASE && halt_out)
        else $error("reset aborted erase");

    erase_ends_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (s_q.state == fsps_pkg::ST_ERASE && s_q.timer == 32'h1)
        |=> !halt_out && s_q.state == fsps_pkg::ST_IDLE)
        else $error("erase did not end with timer");

    rww_clear_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (ctrl_wr && !ee_busy && s_q.state == fsps_pkg::ST_IDLE && cmd5 == `FSPS_CMD_RWW)
        |=> s_q.loaded == 32'h0)
        else $error("buffer kept after rww enable");

endmodule
`default_nettype wire
